//--- sbsp_map.svh
// offsets, widths and timing counts for the burst memory port
// assumes inclusion by the package and the design files
`ifndef SBSP_MAP_SVH
`define SBSP_MAP_SVH
`define SBSP_ADDR_W   16
`define SBSP_DATA_W   18
`define SBSP_BYTE_W   9
`define SBSP_DEPTH    65536
`define SBSP_CNT_W    2
`define SBSP_CLK_NS   25
`endif

//--- sbsp_pkg.sv
// types shared by the burst memory port
// assumes sbsp_map.svh is on the include path
`include "sbsp_map.svh"
package sbsp_pkg;
  typedef enum logic [1:0] {SBSP_IDLE, SBSP_READ, SBSP_WRITE} sbsp_op_t;
  typedef struct packed {
    logic                      start_p_n;
    logic                      start_c_n;
    logic                      advance_n;
    logic                      lower_we_n;
    logic                      upper_we_n;
    logic                      chip_en_n;
    logic [`SBSP_ADDR_W-1:0]   addr;
    logic [`SBSP_DATA_W-1:0]   wdata;
  } sbsp_ctl_t;
endpackage

//--- sbsp_array.sv
// 64K x 18 storage with two nine-bit write lanes and registered read
// assumes write enables and address come from the same clock domain
`include "sbsp_map.svh"
module sbsp_array
  import sbsp_pkg::*;
(
  // clock
  input  wire logic                    clk,
  // access
  input  wire logic [`SBSP_ADDR_W-1:0] addr,
  input  wire logic [1:0]              lane_we,
  input  wire logic [`SBSP_DATA_W-1:0] wdata,
  output logic      [`SBSP_DATA_W-1:0] rdata
);
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_lane
      // each lane owns its storage, so no two processes ever write one variable
      logic [`SBSP_BYTE_W-1:0] mem [0:`SBSP_DEPTH-1];
      logic [`SBSP_BYTE_W-1:0] q_r;
      // RL15 per-lane write
      always_ff @(posedge clk) begin
        if (lane_we[g]) begin
          mem[addr] <= wdata[g*`SBSP_BYTE_W +: `SBSP_BYTE_W];
        end
        q_r <= mem[addr];
      end
    end
  endgenerate

  // read of a word written on the same edge returns the old word
  assign rdata = {g_lane[1].q_r, g_lane[0].q_r};
endmodule // sbsp_array

//--- sbsp_port.sv
// control of a synchronous 64K x 18 burst memory with self-timed write
// assumes pins are synchronous to clk (registered inputs, as a real part)
`include "sbsp_map.svh"
// Function
// RL1 - processor start loads address, forces read
// RL2 - controller start loads address, write or read
// RL3 - advance low steps burst address, accesses
// RL4 - advance high repeats access at current address
// RL5 - inputs captured on rising clock edge
// RL6 - host keeps address and controls valid
// RL7 - host drives valid chip enable
// RL8 - read drives data when output enable low
// RL9 - write or deselect keeps outputs off
// RL10 - host raises output enable before write
// RL11 - outputs off after power up
// RL12 - burst read starts at base address
// RL13 - increment before access, low bits wrap
// RL14 - chip enable sampled only at load
// RL15 - two nine-bit lanes written independently
// RL16 - 65536 words of 18 bits
// RL17 - counter changes only two low bits
// RL18 - write self-timed, only enabled lanes
module sbsp_port
  import sbsp_pkg::*;
(
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    arst_n,
  // burst controls
  input  wire logic                    processor_burst_start_n,
  input  wire logic                    controller_burst_start_n,
  input  wire logic                    burst_advance_n,
  input  wire logic                    lower_byte_write_n,
  input  wire logic                    upper_byte_write_n,
  input  wire logic                    chip_enable_n,
  input  wire logic                    output_enable_n,
  // address and data pins
  input  wire logic [`SBSP_ADDR_W-1:0] address_pins,
  input  wire logic [`SBSP_DATA_W-1:0] data_pins_in,
  output logic      [`SBSP_DATA_W-1:0] data_pins_out,
  output logic                         data_pins_oe_n
);
  // RL5 input registers on the rising edge
  sbsp_ctl_t in_r;
  logic [`SBSP_ADDR_W-1:0] base_r, base_nxt;
  logic [`SBSP_CNT_W-1:0]  cnt_r, cnt_nxt;
  logic                    sel_r, sel_nxt;
  sbsp_op_t                op_r, op_nxt;
  logic                    oe_sync1_r, oe_sync2_r;
  logic [`SBSP_DATA_W-1:0] rdata;
  logic [`SBSP_DATA_W-1:0] data_pins_out_r;
  logic                    oe_n_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      in_r <= '{start_p_n: 1'b1, start_c_n: 1'b1, advance_n: 1'b1, lower_we_n: 1'b1,
                upper_we_n: 1'b1, chip_en_n: 1'b1, addr: '0, wdata: '0};
    end else begin
      in_r <= '{start_p_n: processor_burst_start_n, start_c_n: controller_burst_start_n,
                advance_n: burst_advance_n, lower_we_n: lower_byte_write_n,
                upper_we_n: upper_byte_write_n, chip_en_n: chip_enable_n,
                addr: address_pins, wdata: data_pins_in};
    end
  end

  // decode of the sampled strobes
  wire load_p   = !in_r.start_p_n;
  wire load_c   = in_r.start_p_n && !in_r.start_c_n;
  wire load     = load_p || load_c;
  wire any_we   = !in_r.lower_we_n || !in_r.upper_we_n;
  wire step     = !load && !in_r.advance_n;

  always_comb begin
    base_nxt = base_r;
    cnt_nxt  = cnt_r;
    sel_nxt  = sel_r;
    op_nxt   = SBSP_IDLE;
    if (load) begin
      // RL14 chip enable sampled only on load
      sel_nxt  = !in_r.chip_en_n;
      // RL12 burst starts at external base
      base_nxt = in_r.addr;
      cnt_nxt  = in_r.addr[`SBSP_CNT_W-1:0];
      // RL1 processor start forces read; RL2 controller start by write enables
      if (!in_r.chip_en_n) begin
        op_nxt = (load_c && any_we) ? SBSP_WRITE : SBSP_READ;
      end
    end else if (sel_r) begin
      // RL13 increment before access, wraps in two bits
      if (step) begin
        cnt_nxt = cnt_r + 2'h1;
      end
      // RL3 continue; RL4 suspend repeats current address
      op_nxt = any_we ? SBSP_WRITE : SBSP_READ;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      base_r <= '0;
      cnt_r  <= '0;
      sel_r  <= 1'b0;
      op_r   <= SBSP_IDLE;
    end else begin
      base_r <= base_nxt;
      cnt_r  <= cnt_nxt;
      sel_r  <= sel_nxt;
      op_r   <= op_nxt;
    end
  end

  // RL17 only the low two bits follow the counter
  wire [`SBSP_ADDR_W-1:0] acc_addr = {base_nxt[`SBSP_ADDR_W-1:`SBSP_CNT_W], cnt_nxt};
  // RL18 self-timed write of enabled lanes; RL9 write takes input data
  wire                    do_wr    = (op_nxt == SBSP_WRITE);
  wire [1:0]              lane_we  = {do_wr && !in_r.upper_we_n, do_wr && !in_r.lower_we_n};

  // RL16 full 64K x 18 array
  sbsp_array u_array (
    .clk     (clk),
    .addr    (acc_addr),
    .lane_we (lane_we),
    .wdata   (in_r.wdata),
    .rdata   (rdata)
  );

  // output enable is a pin; synchronised, so it reaches data_pins_oe_n on the third edge in this model
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      oe_sync1_r <= 1'b1;
      oe_sync2_r <= 1'b1;
    end else begin
      oe_sync1_r <= output_enable_n;
      oe_sync2_r <= oe_sync1_r;
    end
  end

  // RL8 drive on read with output enable low; RL9 off for write or deselect
  wire drive_nxt = (op_r == SBSP_READ) && !oe_sync2_r;

  // RL11 outputs off from reset until a read enables them
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      oe_n_r          <= 1'b1;
      data_pins_out_r <= '0;
    end else begin
      oe_n_r          <= !drive_nxt;
      data_pins_out_r <= rdata;
    end
  end

  assign data_pins_out  = data_pins_out_r;
  assign data_pins_oe_n = oe_n_r;

  // RL1 processor start reads
  AST_PROC_READ: assert property (@(posedge clk) disable iff (!arst_n) // RL1
    load_p |=> op_r != SBSP_WRITE)
    else $error("processor start gave write");

  // RL1 no lanes on processor start
  AST_PROC_NO_LANES: assert property (@(posedge clk) disable iff (!arst_n) // RL1
    load_p |-> lane_we == 2'b00)
    else $error("processor start wrote a lane");

  // RL2 controller start writes
  AST_CTRL_WRITE: assert property (@(posedge clk) disable iff (!arst_n) // RL2
    load_c && !in_r.chip_en_n && any_we |=> op_r == SBSP_WRITE)
    else $error("controller write missed");

  // RL3 advance steps counter
  AST_STEP: assert property (@(posedge clk) disable iff (!arst_n) // RL3
    step && sel_r |=> cnt_r == $past(cnt_r) + 2'h1)
    else $error("burst did not step");

  // RL4 suspend holds address
  AST_SUSPEND: assert property (@(posedge clk) disable iff (!arst_n) // RL4
    !load && in_r.advance_n |=> $stable(cnt_r))
    else $error("suspend moved address");

  // RL12 low bits from base
  AST_BASE: assert property (@(posedge clk) disable iff (!arst_n) // RL12
    load |=> cnt_r == $past(in_r.addr[1:0]))
    else $error("base not loaded");

  // RL12 whole base kept
  AST_BASE_ADDR: assert property (@(posedge clk) disable iff (!arst_n) // RL12
    load |=> base_r == $past(in_r.addr))
    else $error("base address not held");

  // RL13 counter wraps to zero
  AST_WRAP: assert property (@(posedge clk) disable iff (!arst_n) // RL13
    step && sel_r && cnt_r == 2'h3 |=> cnt_r == 2'h0)
    else $error("burst did not wrap");

  // RL14 deselect stops driving
  AST_DESEL: assert property (@(posedge clk) disable iff (!arst_n) // RL14
    load && in_r.chip_en_n |=> !sel_r ##1 data_pins_oe_n)
    else $error("deselect drove");

  // RL14 deselected port never writes
  AST_DESEL_NO_WRITE: assert property (@(posedge clk) disable iff (!arst_n) // RL14
    !sel_nxt |-> lane_we == 2'b00)
    else $error("deselected port wrote");

  // RL9 write keeps outputs off
  AST_WRITE_OFF: assert property (@(posedge clk) disable iff (!arst_n) // RL9
    op_r == SBSP_WRITE |=> data_pins_oe_n)
    else $error("drove during write");

  // RL11 idle port stays quiet
  AST_IDLE_QUIET: assert property (@(posedge clk) disable iff (!arst_n) // RL11
    !sel_r && !load |-> ##2 data_pins_oe_n)
    else $error("idle port drove");

  // RL17 upper bits fixed in burst
  AST_UPPER: assert property (@(posedge clk) disable iff (!arst_n) // RL17
    sel_r && !load |-> acc_addr[15:2] == base_r[15:2])
    else $error("upper bits moved");

  // RL8 read drives with enable low
  AST_READ_OE: assert property (@(posedge clk) disable iff (!arst_n) // RL8
    op_r == SBSP_READ && !oe_sync2_r |=> !data_pins_oe_n)
    else $error("read not driven");

  // RL8 enable high keeps outputs off
  AST_OE_HIGH_OFF: assert property (@(posedge clk) disable iff (!arst_n) // RL8
    oe_sync2_r |=> data_pins_oe_n)
    else $error("drove with output enable high");
endmodule // sbsp_port

//--- sbsp_host.sv
// host-side pin model for the burst memory port
// assumes the bench updates req just after each rising clock edge
`include "sbsp_map.svh"
module sbsp_host
  import sbsp_pkg::*;
(
  // request from the bench
  input  wire sbsp_ctl_t               req,
  // device pins
  output logic                         processor_burst_start_n,
  output logic                         controller_burst_start_n,
  output logic                         burst_advance_n,
  output logic                         lower_byte_write_n,
  output logic                         upper_byte_write_n,
  output logic                         chip_enable_n,
  output logic [`SBSP_ADDR_W-1:0]      address_pins,
  output logic [`SBSP_DATA_W-1:0]      data_pins_in,
  input  wire logic [`SBSP_DATA_W-1:0] data_pins_out,
  input  wire logic                    data_pins_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  wire start_w = !req.start_p_n || !req.start_c_n;
  assign processor_burst_start_n  = req.start_p_n;
  assign controller_burst_start_n = req.start_c_n;
  assign burst_advance_n          = req.advance_n;
  assign lower_byte_write_n       = req.lower_we_n;
  assign upper_byte_write_n       = req.upper_we_n;
  assign address_pins  = start_w ? req.addr : ~req.addr;
  assign chip_enable_n = start_w ? req.chip_en_n : ~req.chip_en_n;
  // host off the bus while device drives
  assign data_pins_in = !data_pins_oe_n ? data_pins_out : req.wdata;
endmodule // sbsp_host

//--- sync_burst_sram_port_bench.sv
// self-checking bench for the burst memory port
// assumes the host model turns one request a cycle into pins
`include "sbsp_map.svh"
module sync_burst_sram_port_bench
  import sbsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [5:0] RD_P = 6'h1e, RD_PW = 6'h18, WR_C = 6'h28, RD_C = 6'h2e;
  localparam logic [5:0] ADVW = 6'h30, ADVR = 6'h36, SUS = 6'h3e, DES_W = 6'h29;
  // rows: lower we, upper we, address, first word, second word
  localparam logic [53:0] ROWS [4] = '{{2'b00, 16'h0000, 18'h3ffff, 18'h12345},
    {2'b01, 16'hffff, 18'h3ffff, 18'h00000}, {2'b10, 16'h8001, 18'h00000, 18'h3ffff},
    {2'b11, 16'h4002, 18'h2aaaa, 18'h15555}};
  logic clk, arst_n, output_enable_n, lw, uw;
  sbsp_ctl_t req;
  logic [15:0] ad;
  logic [17:0] w1, w2, data_pins_out;
  logic data_pins_oe_n;
  wire logic pp, pc, pa, plw, puw, pce;
  wire logic [15:0] pad;
  wire logic [17:0] pdi;
  sbsp_ctl_t cq [4];
  logic [17:0] eq [4];
  logic [3:0] ne;
  int n_mismatch = 0;
  int total_checks = 0;
  sbsp_host i_host (.req(req), .processor_burst_start_n(pp), .controller_burst_start_n(pc),
    .burst_advance_n(pa), .lower_byte_write_n(plw), .upper_byte_write_n(puw),
    .chip_enable_n(pce), .address_pins(pad), .data_pins_in(pdi),
    .data_pins_out(data_pins_out), .data_pins_oe_n(data_pins_oe_n));
  sbsp_port i_dut (.clk(clk), .arst_n(arst_n), .processor_burst_start_n(pp),
    .controller_burst_start_n(pc), .burst_advance_n(pa), .lower_byte_write_n(plw),
    .upper_byte_write_n(puw), .chip_enable_n(pce), .output_enable_n(output_enable_n),
    .address_pins(pad), .data_pins_in(pdi), .data_pins_out(data_pins_out),
    .data_pins_oe_n(data_pins_oe_n));
  function automatic sbsp_ctl_t mk(logic [5:0] f, logic [15:0] a, logic [17:0] d);
    return {f, a, d};
  endfunction
  task automatic check(string nm, logic [17:0] seen, logic [17:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // read data of command j lands three edges after it is driven
  task automatic run4;
    for (int i = 0; i < 7; i++) begin
      @(posedge clk);
      req <= (i < 4) ? cq[i] : mk(SUS, 16'h0, 18'h0);
      #1;
      if (i >= 3 && ne[i-3]) check("data_pins_out", data_pins_out, eq[i-3]);
    end
  endtask
  task automatic report_and_stop;
    if (n_mismatch == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #25000;
    n_mismatch++;
    report_and_stop;
  end
  initial begin
    arst_n = 1'b0;
    // enable held high while writes may follow reads
    output_enable_n = 1'b1;
    req = mk(SUS, 16'h0, 18'h0);
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1 check("data_pins_oe_n", {17'h0, data_pins_oe_n}, 18'h1);
    // lane writes, suspended write, processor start ignoring write enables
    for (int r = 0; r < 4; r++) begin
      {lw, uw, ad, w1, w2} = ROWS[r];
      cq = '{mk(WR_C, ad, w1), mk({3'b111, lw, uw, 1'b0}, 16'h0, w2),
             mk(RD_PW, ad, ~w2), mk(SUS, 16'h0, 18'h0)};
      eq[2] = {uw ? w1[17:9] : w2[17:9], lw ? w1[8:0] : w2[8:0]};
      ne = 4'b0100;
      run4;
    end
    // burst write from low bits 2 wraps through 3, 0, 1
    cq = '{mk(WR_C, 16'h5a5e, 18'h10001), mk(ADVW, 16'h0, 18'h20202),
           mk(ADVW, 16'h0, 18'h30303), mk(ADVW, 16'h0, 18'h0f0f0)};
    ne = 4'h0;
    run4;
    // reads from here until output enable goes high again may drive
    output_enable_n <= 1'b0;
    cq = '{mk(RD_P, 16'h5a5c, 18'h0), mk(ADVR, 16'h0, 18'h0), mk(SUS, 16'h0, 18'h0),
           mk(ADVR, 16'h0, 18'h0)};
    eq = '{18'h30303, 18'h0f0f0, 18'h0f0f0, 18'h10001};
    ne = 4'hf;
    run4;
    cq[0] = mk(RD_C, 16'h5a5f, 18'h0);
    eq = '{18'h20202, 18'h30303, 18'h30303, 18'h0f0f0};
    run4;
    check("data_pins_oe_n", {17'h0, data_pins_oe_n}, 18'h0);
    // deselected burst must not write
    cq = '{mk(DES_W, 16'h5a5c, 18'h3ffff), mk(ADVW, 16'h0, 18'h3ffff),
           mk(ADVW, 16'h0, 18'h3ffff), mk(SUS, 16'h0, 18'h0)};
    ne = 4'h0;
    run4;
    check("data_pins_oe_n", {17'h0, data_pins_oe_n}, 18'h1);
    output_enable_n <= 1'b1;
    cq = '{mk(RD_P, 16'h5a5c, 18'h0), mk(ADVR, 16'h0, 18'h0), mk(SUS, 16'h0, 18'h0),
           mk(SUS, 16'h0, 18'h0)};
    eq = '{18'h30303, 18'h0f0f0, 18'h0f0f0, 18'h0f0f0};
    ne = 4'h3;
    run4;
    check("data_pins_oe_n", {17'h0, data_pins_oe_n}, 18'h1);
    // reset in mid-run while the port drives: outputs go quiet at once
    output_enable_n <= 1'b0;
    run4;
    check("data_pins_oe_n", {17'h0, data_pins_oe_n}, 18'h0);
    arst_n <= 1'b0;
    #2 check("data_pins_oe_n", {17'h0, data_pins_oe_n}, 18'h1);
    @(posedge clk) arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1 check("data_pins_oe_n", {17'h0, data_pins_oe_n}, 18'h1);
    report_and_stop;
  end
endmodule // sync_burst_sram_port_bench
